//--- hdl/uart_line_map.svh
// Register offsets, field positions, reset values and timing counts.
// Function
// - Stop-length bit: one stop bit, else 1.5 for 5-bit, 2 otherwise.
// - Parity enable inserts parity after data and checks it on receive.
// - Even-select set gives even total ones, clear gives odd.
// - Stick parity sends and expects 0 if even-select, else 1.
// - Break control forces serial output low outside loopback; transmitter keeps running.
// - Divisor access bit steers shared addresses to the divisor latches.
// - Data-ready sets on a stored character, clears when all read.
// - Overrun sets when an unread character is overwritten; status read clears.
// - FIFO mode overrun only when full; the new character is dropped.
// - Parity error flag, cleared on status read, shown at FIFO head.
// - Framing error on zero first stop bit, per character, shown at head.
// - After framing error the low level is taken as the next start bit.
// - Long low input sets break, loads one zero character, waits for high.
// - Only overrun, parity, framing and break drive the line interrupt.
// - Holding-empty sets when holding data moves out, clears on a write.
// - Transmitter-empty set only when holding store and shifter are empty.
// - Top status bit is 0 in character mode, FIFO error summary otherwise.
// - Outside loopback, each handshake control bit drives its pin inverted.
// - Loopback: output high, input ignored, tx fed to rx, pins high.
// - Loopback keeps interrupts; modem status sourced from control bits.
// - Change flags set on input change, all clear on status read.
// - Ring trailing-edge flag sets when ring input goes low to high.
// - Status bits 4-7 show inverted inputs, or control bits in loopback.
// - Two length bits select 5, 6, 7 or 8 data bits.
// - The receiver checks only the first stop bit.
`ifndef UART_LINE_MAP_SVH
`define UART_LINE_MAP_SVH

`define REG_DATA      3'h0
`define REG_IRQEN     3'h1
`define REG_FIFOCTL   3'h2
`define REG_LINECTL   3'h3
`define REG_HSCTL     3'h4
`define REG_LINESTAT  3'h5
`define REG_HSSTAT    3'h6

`define LC_STOP       2
`define LC_PEN        3
`define LC_EVEN       4
`define LC_STICK      5
`define LC_BREAK      6
`define LC_DIVISOR_ACCESS_SELECT       7
`define HC_LOOP       4
`define FC_ENABLE     0
`define FC_RXRESET    1
`define FC_TXRESET    2

`define LINECTL_RESET 8'h00
`define HSCTL_RESET   5'h00
`define IRQEN_RESET   4'h0
`define DIV_RESET     16'h0001

`define TICK_LAST     5'h0F
`define TICK_MID      5'h07
`define TICK_RESYNC   5'h06
`define STOP_ONE      5'h0F
`define STOP_HALF     5'h17
`define STOP_TWO      5'h1F
`define FIFO_DEPTH    5'h10

`endif

//--- hdl/uart_line_pkg.sv
// Types shared by the line and handshake control logic.
package uart_line_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } tx_state_type;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRK   = 3'b101
  } rx_state_type;
endpackage

//--- hdl/uart_line_and_modem_control.sv
// Line format, line status and handshake control of a serial element.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module uart_line_and_modem_control (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  // Serial line.
  input  wire logic       serialIn,
  output logic            serialOut,
  // Handshake inputs, active low.
  input  wire logic       ctsN,
  input  wire logic       dsrN,
  input  wire logic       riN,
  input  wire logic       dcdN,
  // Handshake outputs, active low.
  output logic            dtrN,
  output logic            rtsN,
  output logic            userOutOneN,
  output logic            userOutTwoN,
  // Interrupt request.
  output logic            irq
);
  import uart_line_pkg::*;

  logic [7:0]   lineCtl_q;
  logic [4:0]   hsCtl_q;
  logic [3:0]   irqEn_q;
  logic [15:0]  divisor_q;
  logic [15:0]  baudCnt_q;
  logic         fifoMode_q;
  logic [7:0]   txMem [16];
  logic [3:0]   txWr_q;
  logic [3:0]   txRd_q;
  logic [4:0]   txCnt_q;
  tx_state_type txState_q;
  logic [7:0]   txShift_q;
  logic [2:0]   txBit_q;
  logic [4:0]   txTick_q;
  logic         txPar_q;
  logic         txLine_q;
  logic [10:0]  rxMem [16];
  logic [3:0]   rxWr_q;
  logic [3:0]   rxRd_q;
  logic [4:0]   rxCnt_q;
  rx_state_type rxState_q;
  logic [7:0]   rxShift_q;
  logic [2:0]   rxBit_q;
  logic [4:0]   rxTick_q;
  logic         rxParErr_q;
  logic         rxZero_q;
  logic         headNew_q;
  logic         overrun_q;
  logic         parErr_q;
  logic         frmErr_q;
  logic         brk_q;
  logic [3:0]   hsPrev_q;
  logic [3:0]   delta_q;
  logic         anyErr;

  // Parity bit for a character under the current line format.
  function automatic logic parityOf(input logic [7:0] d,
                                    input logic [7:0] lc);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - lc[1:0]);
    if (lc[`LC_STICK]) begin
      parityOf = ~lc[`LC_EVEN];
    end else begin
      parityOf = (^(d & mask)) ^ ~lc[`LC_EVEN];
    end
  endfunction

  // Register decode.
  // divisor access steering
  wire divisor_access_select       = lineCtl_q[`LC_DIVISOR_ACCESS_SELECT];
  wire loop       = hsCtl_q[`HC_LOOP];
  wire wrDataReg  = wrStrobe && addr == `REG_DATA && !divisor_access_select;
  wire wrDivLo    = wrStrobe && addr == `REG_DATA && divisor_access_select;
  wire wrIrqEn    = wrStrobe && addr == `REG_IRQEN && !divisor_access_select;
  wire wrDivHi    = wrStrobe && addr == `REG_IRQEN && divisor_access_select;
  wire wrFifoCtl  = wrStrobe && addr == `REG_FIFOCTL;
  wire wrLineCtl  = wrStrobe && addr == `REG_LINECTL;
  wire wrHsCtl    = wrStrobe && addr == `REG_HSCTL;
  wire rdDataReg  = rdStrobe && addr == `REG_DATA && !divisor_access_select;
  wire rdLineStat = rdStrobe && addr == `REG_LINESTAT;
  wire rdHsStat   = rdStrobe && addr == `REG_HSSTAT;
  wire modeChange = wrFifoCtl && (wrData[`FC_ENABLE] != fifoMode_q);
  wire rxFlush    = modeChange || (wrFifoCtl && wrData[`FC_RXRESET]);
  wire txFlush    = modeChange || (wrFifoCtl && wrData[`FC_TXRESET]);
  wire [4:0] cap  = fifoMode_q ? `FIFO_DEPTH : 5'h01;

  // Baud tick at sixteen times the bit rate.
  wire tick16 = baudCnt_q <= 16'h0001;

  // Format decode.
  // character length
  wire [2:0] lastBit = 3'h4 + {1'b0, lineCtl_q[1:0]};
  wire       pen     = lineCtl_q[`LC_PEN];
  wire [4:0] stopEnd = !lineCtl_q[`LC_STOP] ? `STOP_ONE :
                       (lineCtl_q[1:0] == 2'b00) ? `STOP_HALF : `STOP_TWO;

  // Transmit store and sequencer.
  wire txFull  = txCnt_q >= cap;
  wire txPush  = wrDataReg && !txFull;
  wire txPop   = tick16 && txState_q == TX_IDLE && txCnt_q != 5'h00;
  wire txLast  = txTick_q == `TICK_LAST;
  wire tx_holding_empty_flag    = txCnt_q == 5'h00;
  wire tx_all_empty_flag    = tx_holding_empty_flag && txState_q == TX_IDLE;

  wire rxIn    = loop ? txLine_q : serialIn;

  // Receive store.
  wire rxLast   = rxTick_q == `TICK_LAST;
  wire rxPushEv = tick16 && rxState_q == RX_STOP && rxLast;
  wire rxFull   = rxCnt_q >= cap;
  wire rxPop    = rdDataReg && rxCnt_q != 5'h00;
  wire rxAccept = rxPushEv && (!rxFull || rxPop);
  wire overrunEv = rxPushEv && rxFull && !rxPop;
  wire overwrite = overrunEv && !fifoMode_q;
  wire brkEv    = rxZero_q && !rxIn;
  wire [7:0] rxAligned = rxShift_q >> (2'h3 - lineCtl_q[1:0]);
  wire [10:0] rxEntry = brkEv ? 11'h600 :
                        {1'b0, !rxIn, rxParErr_q, rxAligned};
  wire headNewEv = (rxAccept && rxCnt_q == {4'h0, rxPop}) ||
                   (rxPop && rxCnt_q > 5'h01) || overwrite;
  wire [10:0] head = rxMem[rxRd_q];
  wire dr = rxCnt_q != 5'h00;

  // Handshake status.
  // status source
  wire [3:0] hsStat = loop ? {hsCtl_q[3], hsCtl_q[2], hsCtl_q[0], hsCtl_q[1]}
                           : {~dcdN, ~riN, ~dsrN, ~ctsN};
  wire [3:0] deltaEv = {hsStat[3] ^ hsPrev_q[3], hsPrev_q[2] & ~hsStat[2],
                        hsStat[1] ^ hsPrev_q[1], hsStat[0] ^ hsPrev_q[0]};

  always_comb begin
    anyErr = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if ({1'b0, 4'(i) - rxRd_q} < rxCnt_q && |rxMem[i][10:8]) begin
        anyErr = 1'b1;
      end
    end
  end

  wire [7:0] lineStat = {fifoMode_q & anyErr, tx_all_empty_flag, tx_holding_empty_flag, brk_q, frmErr_q,
                         parErr_q, overrun_q, dr};
  wire [7:0] rdMux =
    (addr == `REG_DATA)     ? (divisor_access_select ? divisor_q[7:0] : head[7:0]) :
    (addr == `REG_IRQEN)    ? (divisor_access_select ? divisor_q[15:8] : {4'h0, irqEn_q}) :
    (addr == `REG_FIFOCTL)  ? {7'h00, fifoMode_q} :
    (addr == `REG_LINECTL)  ? lineCtl_q :
    (addr == `REG_HSCTL)    ? {3'h0, hsCtl_q} :
    (addr == `REG_LINESTAT) ? lineStat :
    (addr == `REG_HSSTAT)   ? {hsStat, delta_q} : 8'h00;

  wire lineIrq = overrun_q | parErr_q | frmErr_q | brk_q;
  wire irqNext = |(irqEn_q & {|delta_q, lineIrq, tx_holding_empty_flag, dr});

  // Control registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineCtl_q  <= `LINECTL_RESET;
      hsCtl_q    <= `HSCTL_RESET;
      irqEn_q    <= `IRQEN_RESET;
      divisor_q  <= `DIV_RESET;
      fifoMode_q <= 1'b0;
    end else begin
      if (wrLineCtl) lineCtl_q <= wrData;
      if (wrHsCtl) hsCtl_q <= wrData[4:0];
      if (wrIrqEn) irqEn_q <= wrData[3:0];
      if (wrDivLo) divisor_q[7:0] <= wrData;
      if (wrDivHi) divisor_q[15:8] <= wrData;
      if (wrFifoCtl) fifoMode_q <= wrData[`FC_ENABLE];
    end
  end

  // Baud counter, reloaded whenever a divisor latch is written.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_q <= `DIV_RESET;
    end else if (wrDivLo || wrDivHi || tick16) begin
      baudCnt_q <= divisor_q;
    end else begin
      baudCnt_q <= baudCnt_q - 16'h0001;
    end
  end

  // Transmit store pointers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txWr_q  <= 4'h0;
      txRd_q  <= 4'h0;
      txCnt_q <= 5'h00;
    end else if (txFlush) begin
      txWr_q  <= 4'h0;
      txRd_q  <= 4'h0;
      txCnt_q <= 5'h00;
    end else begin
      if (txPush) txWr_q <= txWr_q + 4'h1;
      if (txPop) txRd_q <= txRd_q + 4'h1;
      txCnt_q <= txCnt_q + {4'h0, txPush} - {4'h0, txPop};
    end
  end

  always_ff @(posedge clk) begin
    if (txPush) txMem[txWr_q] <= wrData;
  end

  // Transmit sequencer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_q <= TX_IDLE;
      txShift_q <= 8'h00;
      txBit_q   <= 3'h0;
      txTick_q  <= 5'h00;
      txPar_q   <= 1'b0;
      txLine_q  <= 1'b1;
    end else if (tick16) begin
      txTick_q <= txTick_q + 5'h01;
      unique case (txState_q)
        TX_IDLE: begin
          txTick_q <= 5'h00;
          if (txPop) begin
            txShift_q <= txMem[txRd_q];
            txPar_q   <= parityOf(txMem[txRd_q], lineCtl_q);
            txLine_q  <= 1'b0;
            txState_q <= TX_START;
          end
        end
        TX_START: begin
          if (txLast) begin
            txTick_q  <= 5'h00;
            txBit_q   <= 3'h0;
            txLine_q  <= txShift_q[0];
            txState_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txLast) begin
            txTick_q <= 5'h00;
            if (txBit_q == lastBit) begin
              txLine_q  <= pen ? txPar_q : 1'b1;
              txState_q <= pen ? TX_PAR : TX_STOP;
            end else begin
              txShift_q <= {1'b0, txShift_q[7:1]};
              txLine_q  <= txShift_q[1];
              txBit_q   <= txBit_q + 3'h1;
            end
          end
        end
        TX_PAR: begin
          if (txLast) begin
            txTick_q  <= 5'h00;
            txLine_q  <= 1'b1;
            txState_q <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (txTick_q == stopEnd) begin
            txTick_q  <= 5'h00;
            txState_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive sequencer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_q  <= RX_IDLE;
      rxShift_q  <= 8'h00;
      rxBit_q    <= 3'h0;
      rxTick_q   <= 5'h00;
      rxParErr_q <= 1'b0;
      rxZero_q   <= 1'b0;
    end else if (tick16) begin
      rxTick_q <= rxTick_q + 5'h01;
      unique case (rxState_q)
        RX_IDLE: begin
          rxTick_q <= 5'h00;
          if (!rxIn) rxState_q <= RX_START;
        end
        RX_START: begin
          if (rxTick_q == `TICK_MID) begin
            rxTick_q   <= 5'h00;
            rxBit_q    <= 3'h0;
            rxParErr_q <= 1'b0;
            rxZero_q   <= 1'b1;
            rxState_q  <= rxIn ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxLast) begin
            rxTick_q  <= 5'h00;
            rxShift_q <= {rxIn, rxShift_q[7:1]};
            rxZero_q  <= rxZero_q & !rxIn;
            if (rxBit_q == lastBit) begin
              rxState_q <= pen ? RX_PAR : RX_STOP;
            end else begin
              rxBit_q <= rxBit_q + 3'h1;
            end
          end
        end
        RX_PAR: begin
          if (rxLast) begin
            rxTick_q <= 5'h00;
            rxParErr_q <= rxIn != parityOf(rxAligned, lineCtl_q);
            rxZero_q   <= rxZero_q & !rxIn;
            rxState_q  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxLast) begin
            rxTick_q <= 5'h00;
            if (brkEv) begin
              rxState_q <= RX_BRK;
            end else if (!rxIn) begin
              rxTick_q  <= `TICK_RESYNC;
              rxState_q <= RX_START;
            end else begin
              rxState_q <= RX_IDLE;
            end
          end
        end
        RX_BRK: begin
          rxTick_q <= 5'h00;
          if (rxIn) rxState_q <= RX_IDLE;
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Receive store pointers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWr_q  <= 4'h0;
      rxRd_q  <= 4'h0;
      rxCnt_q <= 5'h00;
    end else if (rxFlush) begin
      rxWr_q  <= 4'h0;
      rxRd_q  <= 4'h0;
      rxCnt_q <= 5'h00;
    end else begin
      if (rxAccept) rxWr_q <= rxWr_q + 4'h1;
      if (rxPop) rxRd_q <= rxRd_q + 4'h1;
      rxCnt_q <= rxCnt_q + {4'h0, rxAccept} - {4'h0, rxPop};
    end
  end

  always_ff @(posedge clk) begin
    if (rxAccept) begin
      rxMem[rxWr_q] <= rxEntry;
    end else if (overwrite) begin
      rxMem[rxRd_q] <= rxEntry;
    end
  end

  // Line status flags; a new event wins over the clearing read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      headNew_q <= 1'b0;
      overrun_q <= 1'b0;
      parErr_q  <= 1'b0;
      frmErr_q  <= 1'b0;
      brk_q     <= 1'b0;
    end else begin
      headNew_q <= headNewEv && !rxFlush;
      overrun_q <= (overrun_q & !rdLineStat) | overrunEv;
      parErr_q  <= (parErr_q & !rdLineStat) | (headNew_q & head[8]);
      frmErr_q  <= (frmErr_q & !rdLineStat) | (headNew_q & head[9]);
      brk_q     <= (brk_q & !rdLineStat) | (headNew_q & head[10]);
    end
  end

  // Handshake change flags.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hsPrev_q <= 4'h0;
      delta_q  <= 4'h0;
    end else begin
      hsPrev_q <= hsStat;
      delta_q  <= (delta_q & {4{!rdHsStat}}) | deltaEv;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData      <= 8'h00;
      serialOut   <= 1'b1;
      dtrN        <= 1'b1;
      rtsN        <= 1'b1;
      userOutOneN <= 1'b1;
      userOutTwoN <= 1'b1;
      irq         <= 1'b0;
    end else begin
      rdData      <= rdStrobe ? rdMux : 8'h00;
      serialOut   <= loop | (txLine_q & !lineCtl_q[`LC_BREAK]);
      dtrN        <= loop | ~hsCtl_q[0];
      rtsN        <= loop | ~hsCtl_q[1];
      userOutOneN <= loop | ~hsCtl_q[2];
      userOutTwoN <= loop | ~hsCtl_q[3];
      irq         <= irqNext;
    end
  end
endmodule // uart_line_and_modem_control

//--- testbench/uart_line_and_modem_control_asserts.sv
// Port-level checker for the line and handshake control block.
`timescale 1ns/1ps
module uart_line_and_modem_control_asserts (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port.
  input wire logic [2:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic [7:0] rdData,
  // Serial and handshake lines.
  input wire logic       serialIn,
  input wire logic       serialOut,
  input wire logic       ctsN,
  input wire logic       dsrN,
  input wire logic       riN,
  input wire logic       dcdN,
  input wire logic       dtrN,
  input wire logic       rtsN,
  input wire logic       userOutOneN,
  input wire logic       userOutTwoN,
  input wire logic       irq
);
  logic [3:0] hsIn;
  logic [3:0] quiet_q;
  logic       loopMode_q;
  wire        wrHs  = wrStrobe && addr == 3'h4;
  wire        wrFmt = wrStrobe && addr == 3'h3;
  wire        rdHs  = rdStrobe && addr == 3'h6;
  assign hsIn = {dcdN, riN, dsrN, ctsN};
  // Loopback holds the line high, so break is only checked outside it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loopMode_q <= 1'b0;
    end else if (wrHs) begin
      loopMode_q <= wrData[4];
    end
  end
  // Counts cycles since the handshake inputs last moved.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 4'h0;
    end else if (!$stable(hsIn)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rdPair;
    rdHs ##[1:8] (rdHs && !dtrN && quiet_q == 4'hF);
  endsequence
  sequence s_lowBit;
    !serialOut [*8] ##1 !serialOut [*8];
  endsequence
  sequence s_highBit;
    serialOut [*8] ##1 serialOut [*8];
  endsequence
  property p_hsPins;
    (wrHs ##1 !wrHs) |=> {userOutTwoN, userOutOneN, rtsN, dtrN} ==
      (~$past(wrData[3:0], 2) | {4{$past(wrData[4], 2)}});
  endproperty
  a_hsPins: assert property (p_hsPins) else $error("pins wrong");
  property p_loopOut;
    (wrHs && wrData[4]) ##1 !wrHs |-> ##[0:2] serialOut;
  endproperty
  a_loopOut: assert property (p_loopOut) else $error("loop out");
  property p_breakLow;
    (wrFmt && wrData[6] && !loopMode_q) ##1 !(wrFmt || wrHs) |->
      ##[0:2] !serialOut;
  endproperty
  a_breakLow: assert property (p_breakLow) else $error("break");
  property p_unusedZero;
    rdStrobe && addr == 3'h4 |=> rdData[7:5] == 3'h0;
  endproperty
  a_unusedZero: assert property (p_unusedZero) else $error("bits");
  property p_hsStatus;
    rdHs && !dtrN && quiet_q >= 4'h3 |=> rdData[7:4] == ~$past(hsIn);
  endproperty
  a_hsStatus: assert property (p_hsStatus) else $error("hs in");
  property p_deltaClear;
    s_rdPair |=> rdData[3:0] == 4'h0;
  endproperty
  a_deltaClear: assert property (p_deltaClear) else $error("dlt");
  property p_lowRun;
    $fell(serialOut) |-> s_lowBit;
  endproperty
  a_lowRun: assert property (p_lowRun) else $error("short low");
  property p_highRun;
    $rose(serialOut) |-> s_highBit;
  endproperty
  a_highRun: assert property (p_highRun) else $error("short hi");
endmodule // uart_line_and_modem_control_asserts

bind uart_line_and_modem_control uart_line_and_modem_control_asserts portChk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .serialIn(serialIn), .serialOut(serialOut), .ctsN(ctsN),
  .dsrN(dsrN), .riN(riN), .dcdN(dcdN), .dtrN(dtrN), .rtsN(rtsN),
  .userOutOneN(userOutOneN), .userOutTwoN(userOutTwoN), .irq(irq)
);

//--- testbench/uart_modem_model.sv
// Modem-side model: serial sender and handshake line drivers.
`timescale 1ns/1ps
module uart_modem_model (
  // Clock.
  input  wire logic clk,
  // Serial line towards the block.
  output logic      serialIn,
  // Handshake lines, active low.
  output logic      ctsN,
  output logic      dsrN,
  output logic      riN,
  output logic      dcdN
);
  initial begin
    serialIn = 1'b1;
    {dcdN, riN, dsrN, ctsN} = 4'hF;
  end
  function automatic logic parOf(input logic [7:0] lc, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hFF >> (3 - lc[1:0]));
    if (lc[5]) return !lc[4];
    return lc[4] ? ^m : ~^m;
  endfunction
  task automatic bitOut(input logic v, input int n);
    serialIn <= v;
    repeat (n) @(posedge clk);
  endtask
  // Flags: bit 0 wrong parity, bit 1 zero stop, bit 2 no start bit.
  task automatic send(input logic [7:0] lc, input logic [7:0] d,
                      input logic [2:0] fl);
    int i;
    if (!fl[2]) bitOut(1'b0, 16);
    for (i = 0; i < 5 + lc[1:0]; i++) bitOut(d[i], 16);
    if (lc[3]) bitOut(parOf(lc, d) ^ fl[0], 16);
    bitOut(!fl[1], 16);
  endtask
  task automatic brk(input int n);
    bitOut(1'b0, n);
    bitOut(1'b1, 32);
  endtask
  task automatic setHs(input logic [3:0] v);
    @(posedge clk);
    {dcdN, riN, dsrN, ctsN} <= v;
    repeat (16) @(posedge clk);
  endtask
endmodule // uart_modem_model

//--- testbench/testbench.sv
// Self-checking bench for the line and handshake control block.
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wrData;
  logic       wrStrobe;
  logic       rdStrobe;
  logic [7:0] rdData;
  logic       serialIn;
  logic       serialOut;
  logic       ctsN;
  logic       dsrN;
  logic       riN;
  logic       dcdN;
  logic       dtrN;
  logic       rtsN;
  logic       userOutOneN;
  logic       userOutTwoN;
  logic       irq;
  logic [3:0] pins;
  int         nErrors;
  int         checked;
  int         cycles;
  int         k;
  logic       halves[$];
  logic [7:0] lcs[8] = '{8'h03, 8'h1B, 8'h0B, 8'h2B, 8'h3B, 8'h04,
                         8'h0E, 8'h19};
  assign pins = {userOutTwoN, userOutOneN, rtsN, dtrN};
  uart_line_and_modem_control DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .serialIn(serialIn), .serialOut(serialOut), .ctsN(ctsN),
    .dsrN(dsrN), .riN(riN), .dcdN(dcdN), .dtrN(dtrN), .rtsN(rtsN),
    .userOutOneN(userOutOneN), .userOutTwoN(userOutTwoN), .irq(irq)
  );
  uart_modem_model partner (
    .clk(clk), .serialIn(serialIn), .ctsN(ctsN), .dsrN(dsrN),
    .riN(riN), .dcdN(dcdN)
  );
  always #4 clk = ~clk;
  task automatic tally_and_finish;
    $display("checked %0d nErrors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nErrors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] g,
                     input logic [7:0] e);
    checked++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [2:0] a,
                     input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    chk(nm, rdData, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic void put(input logic v, input int n);
    repeat (n) halves.push_back(v);
  endfunction
  // Sends d then ~d back to back and samples the line every half bit.
  task automatic txCheck(input logic [7:0] lc, input logic [7:0] d);
    logic [7:0] e;
    int i;
    int n;
    n = 5 + lc[1:0];
    halves = {};
    for (i = 0; i < 2; i++) begin
      e = i ? ~d : d;
      put(1'b0, 2);
      for (int b = 0; b < n; b++) put(e[b], 2);
      if (lc[3]) put(partner.parOf(lc, e), 2);
      put(1'b1, !lc[2] ? 2 : (n == 5 ? 3 : 4));
    end
    put(1'b1, 2);
    wr(3'h3, lc);
    wr(3'h0, d);
    i = 0;
    while (serialOut !== 1'b0 && i < 100) begin
      settle(1);
      i++;
    end
    wr(3'h0, ~d);
    settle(2);
    foreach (halves[j]) begin
      chk("serial_out_pin", {7'h0, serialOut}, {7'h0, halves[j]});
      settle(8);
    end
    rdc("lineStat", 3'h5, 8'h60);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 3'h0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    nErrors = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc("lineFmt", 3'h3, 8'h00);
    rdc("lineStat", 3'h5, 8'h60);
    rdc("hsCtl", 3'h4, 8'h00);
    rdc("hsStat", 3'h6, 8'h00);
    rdc("unmapped", 3'h7, 8'h00);
    chk("pins", {4'h0, pins}, 8'h0F);
    wr(3'h1, 8'h0A);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rdc("divHigh", 3'h1, 8'h00);
    rdc("divLow", 3'h0, 8'h01);
    rdc("lineFmt", 3'h3, 8'h80);
    wr(3'h3, 8'h03);
    rdc("irqEn", 3'h1, 8'h0A);
    settle(3);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(3'h1, 8'h00);
    for (k = 0; k < 8; k++) txCheck(lcs[k], 8'hC6 + k);
    wr(3'h3, 8'h43);
    wr(3'h0, 8'h55);
    settle(300);
    chk("serial_out_pin", {7'h0, serialOut}, 8'h00);
    rdc("lineStat", 3'h5, 8'h60);
    wr(3'h3, 8'h1B);
    wr(3'h1, 8'h04);
    partner.send(8'h1B, 8'h11, 3'b000);
    chk("irq", {7'h0, irq}, 8'h00);
    partner.send(8'h1B, 8'h22, 3'b000);
    chk("irq", {7'h0, irq}, 8'h01);
    rdc("lineStat", 3'h5, 8'h63);
    rdc("rxData", 3'h0, 8'h22);
    rdc("lineStat", 3'h5, 8'h60);
    @(posedge clk);
    partner.send(8'h1B, 8'h5C, 3'b001);
    chk("irq", {7'h0, irq}, 8'h01);
    rdc("lineStat", 3'h5, 8'h65);
    settle(3);
    chk("irq", {7'h0, irq}, 8'h00);
    rdc("rxData", 3'h0, 8'h5C);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    partner.brk(400);
    rdc("lineStat", 3'h5, 8'h79);
    rdc("rxData", 3'h0, 8'h00);
    rdc("lineStat", 3'h5, 8'h60);
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h07);
    partner.send(8'h07, 8'h3C, 3'b010);
    partner.send(8'h07, 8'hA7, 3'b100);
    partner.send(8'h07, 8'h5E, 3'b000);
    rdc("lineStat", 3'h5, 8'hE9);
    rdc("rxData", 3'h0, 8'h3C);
    rdc("lineStat", 3'h5, 8'h61);
    rdc("rxData", 3'h0, 8'hA7);
    rdc("rxData", 3'h0, 8'h5E);
    wr(3'h3, 8'h03);
    for (k = 0; k < 17; k++) partner.send(8'h03, k[7:0], 3'b000);
    rdc("lineStat", 3'h5, 8'h63);
    for (k = 0; k < 16; k++) rdc("rxData", 3'h0, k[7:0]);
    rdc("lineStat", 3'h5, 8'h60);
    wr(3'h4, 8'hE5);
    rdc("hsCtl", 3'h4, 8'h05);
    chk("pins", {4'h0, pins}, 8'h0A);
    wr(3'h1, 8'h08);
    partner.setHs(4'b0110);
    chk("irq", {7'h0, irq}, 8'h01);
    rdc("hsStat", 3'h6, 8'h99);
    rdc("hsStat", 3'h6, 8'h90);
    settle(3);
    chk("irq", {7'h0, irq}, 8'h00);
    partner.setHs(4'b0010);
    rdc("hsStat", 3'h6, 8'hD0);
    partner.setHs(4'b0110);
    rdc("hsStat", 3'h6, 8'h94);
    partner.setHs(4'hF);
    rdc("hsStat", 3'h6, 8'h09);
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h13);
    settle(3);
    chk("pins", {4'h0, pins}, 8'h0F);
    chk("irq", {7'h0, irq}, 8'h01);
    rdc("hsStat", 3'h6, 8'h33);
    wr(3'h0, 8'h3C);
    settle(200);
    chk("serial_out_pin", {7'h0, serialOut}, 8'h01);
    rdc("lineStat", 3'h5, 8'h61);
    rdc("rxData", 3'h0, 8'h3C);
    tally_and_finish();
  end
endmodule // testbench
